// ==== shared/bsi_pkg.sv ====
// constants for the status and interrupt-mask block
// assumes an 8-bit register port with 5-bit addresses
package bsi_pkg;
  localparam logic [4:0] BSI_STATUS_ADDR = 5'h14;
  localparam logic [4:0] BSI_MASK_ADDR   = 5'h15;
  localparam int BSI_LOCK_BIT  = 0;
  localparam int BSI_ECOV_BIT  = 1;
  localparam int BSI_BCOV_BIT  = 2;
  localparam int BSI_ERR_BIT   = 3;
  localparam int BSI_LOSS_BIT  = 4;
  localparam int BSI_ZERO_BIT  = 5;
  localparam int BSI_ONES_BIT  = 6;
  localparam logic [7:0] BSI_MASK_RESET   = 8'h00;
  localparam logic [7:0] BSI_STATUS_RESET = 8'h00;
  localparam logic [7:0] BSI_RUN_MAX      = 8'h20;
endpackage : bsi_pkg

// ==== src/bsi_status_irq.sv ====
// status register, interrupt mask and active-low interrupt of the tester
// assumes rx inputs come from another domain; host strobes are synchronous pulses
//
// Notes on behaviour
// - status register at 0x14: lock bit0, flags bits1..6, bit7 reads zero.
// - mask register at 0x15, bits 0..6 match status bit positions.
// - mask one enables a flag's interrupt; zero blocks it, flag still records.
// - sync loss flag set while synchronizer hunts for lock.
// - sync loss flag stays set after lock until status is read.
// - mask bit 4 gates sync loss, mask bit 1 gates error count overflow.
// - error, bit overflow, error overflow latch; read clears; set on new event.
// - read clears sync loss and run alarms only once condition ended.
// - lock bit is live; all other flags latch.
// - interrupt low while any flag and its mask bit are both one.
`timescale 1ns/1ps
module bsi_status_irq
  import bsi_pkg::*;
#(
  parameter logic [7:0] RUN_LIMIT = BSI_RUN_MAX
) (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic [4:0] addr,
  input  wire logic       rd_stb,
  input  wire logic       wr_stb,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  output logic            irq_n,
  input  wire logic       rx_in_lock,
  input  wire logic       rx_bit_valid,
  input  wire logic       rx_bit,
  input  wire logic       rx_bit_error,
  input  wire logic       bit_count_wrap,
  input  wire logic       error_count_wrap
);
  // ==========================================================
  // synchronisers
  logic [5:0] sync_a;
  logic [5:0] sync_b;
  logic [5:0] sync_c;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
      sync_c <= 6'h00;
    end else begin
      sync_a <= {error_count_wrap, bit_count_wrap, rx_bit_error,
                 rx_bit, rx_bit_valid, rx_in_lock};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end
  // event inputs are toggles-free levels; rising edges count as one event
  logic lock_now;
  logic bit_stb;
  logic err_evt;
  logic bcov_evt;
  logic ecov_evt;
  assign lock_now = sync_b[0];
  assign bit_stb  = sync_b[1] & ~sync_c[1];
  assign err_evt  = sync_b[3] & ~sync_c[3];
  assign bcov_evt = sync_b[4] & ~sync_c[4];
  assign ecov_evt = sync_b[5] & ~sync_c[5];

  // ==========================================================
  // run-length detector for all-ones and all-zeros
  logic [7:0] run_len;
  logic       last_bit;
  logic       ones_cond;
  logic       zero_cond;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      run_len  <= 8'h00;
      last_bit <= 1'b0;
    end else if (bit_stb) begin
      last_bit <= sync_b[2];
      if (sync_b[2] != last_bit || run_len == 8'h00) begin
        run_len <= 8'h01;
      end else if (run_len != RUN_LIMIT) begin
        run_len <= run_len + 8'h01;
      end
    end
  end
  assign ones_cond = (run_len == RUN_LIMIT) &  last_bit;
  assign zero_cond = (run_len == RUN_LIMIT) & ~last_bit;

  // ==========================================================
  // status flags
  logic       status_rd;
  logic [6:1] flags;
  logic [6:1] cond;
  logic [6:1] evt;
  assign status_rd = rd_stb & (addr == BSI_STATUS_ADDR);
  always_comb begin
    cond = 6'h00;
    evt  = 6'h00;
    evt[BSI_ECOV_BIT] = ecov_evt;
    evt[BSI_BCOV_BIT] = bcov_evt;
    evt[BSI_ERR_BIT]  = err_evt;
    cond[BSI_LOSS_BIT] = ~lock_now;
    cond[BSI_ZERO_BIT] = zero_cond;
    cond[BSI_ONES_BIT] = ones_cond;
    evt = evt | cond;
  end
  // set wins over the read-clear; persisting conditions re-set at once
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flags <= BSI_STATUS_RESET[6:1];
    end else if (status_rd) begin
      flags <= evt;
    end else begin
      flags <= flags | evt;
    end
  end

  // ==========================================================
  // mask register and read port
  logic [7:0] mask;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mask <= BSI_MASK_RESET;
    end else if (wr_stb && addr == BSI_MASK_ADDR) begin
      mask <= {1'b0, wr_data[6:0]};
    end
  end
  logic [7:0] status_view;
  assign status_view = {1'b0, flags, lock_now};
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_data <= 8'h00;
    end else if (rd_stb) begin
      unique case (addr)
        BSI_STATUS_ADDR: rd_data <= status_view;
        BSI_MASK_ADDR:   rd_data <= mask;
        default:         rd_data <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // interrupt output
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~|(status_view[6:0] & mask[6:0]);
    end
  end
endmodule : bsi_status_irq

// ==== verif/bsi_host_model.sv ====
// host side: one register access per call
// assumes the block samples strobes on rising edges
`timescale 1ns/1ps
module bsi_host_model (
  input  wire logic       clock,
  input  wire logic [7:0] rd_data,
  output logic      [4:0] addr,
  output logic            rd_stb,
  output logic            wr_stb,
  output logic      [7:0] wr_data
);
  initial {addr, rd_stb, wr_stb, wr_data} = '0;
  task automatic x(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(negedge clock);
    {addr, wr_data, rd_stb, wr_stb} = {a, d & 8'h7f, !w, w};
    @(negedge clock);
    {rd_stb, wr_stb, wr_data} = {2'b00, ~wr_data};
  endtask : x
endmodule : bsi_host_model

// ==== verif/bsi_status_irq_monitor.sv ====
// checker on the register port and interrupt pin
// assumes lock input held steady around status reads
`timescale 1ns/1ps
module bsi_status_irq_monitor (
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       rd_stb,
  input wire logic       wr_stb,
  input wire logic       irq_n,
  input wire logic       rx_in_lock,
  input wire logic [4:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  wire rs = rd_stb && addr == 5'h14;
  wire wm = wr_stb && addr == 5'h15;
  a_unmapped_zero: assert property (
    rd_stb && addr < 5'h14 |=> rd_data == 8'h00) else $error("unmapped read");
  a_status_top: assert property (rs |=> !rd_data[7]) else $error("bit7 set");
  a_read_holds: assert property (!rd_stb |=> $stable(rd_data)) else $error("rd moved");
  a_mask_back: assert property (
    wm ##2 rd_stb && addr == 5'h15 |=> rd_data == {1'b0, $past(wr_data[6:0], 3)})
    else $error("mask");
  a_mask_quiet: assert property (wm && wr_data == 8'h00 |-> ##3 irq_n) else $error("irq");
  a_loss_irq: assert property (
    wm && wr_data == 8'h10 && !rx_in_lock && !$past(rx_in_lock, 4) |-> ##3 !irq_n)
    else $error("no irq");
  a_lock_live: assert property (
    rs && rx_in_lock && $past(rx_in_lock, 3) |=> rd_data[0]) else $error("lock");
  a_loss_hunt: assert property (
    rs && !rx_in_lock && !$past(rx_in_lock, 3) |=> rd_data[4] && !rd_data[0]) else $error("loss");
endmodule : bsi_status_irq_monitor
bind bsi_status_irq bsi_status_irq_monitor bsi_status_irq_monitor_inst (.clock, .rstn,
  .rd_stb, .wr_stb, .irq_n, .rx_in_lock, .addr, .wr_data, .rd_data);

// ==== verif/bsi_status_irq_tb.sv ====
// bench: mask, flags and interrupt pin
// assumes the host model owns the register port
`timescale 1ns/1ps
`define CHK(n, e, v) begin cmp_count++; if ((v) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", n, e, v); end end
module bsi_status_irq_tb;
  import bsi_pkg::*;
  logic clock = 0, rstn = 0, rx_in_lock = 0, rx_bit_error = 0, bit_count_wrap = 0;
  logic error_count_wrap = 0, rd_stb, wr_stb, irq_n;
  logic rx_bit_valid = 0, rx_bit = 0;
  logic [4:0] addr;
  logic [7:0] wr_data, rd_data;
  int failures = 0, cmp_count = 0;
  always #10 clock = ~clock;
  bsi_status_irq bsi_status_irq_inst (.clock, .rstn, .addr, .rd_stb, .wr_stb, .wr_data,
    .rd_data, .irq_n, .rx_in_lock, .rx_bit_valid, .rx_bit, .rx_bit_error,
    .bit_count_wrap, .error_count_wrap);
  bsi_host_model bsi_host_model_inst (.clock, .rd_data, .addr, .rd_stb, .wr_stb, .wr_data);
  task automatic x(input logic w, input logic [4:0] a, input logic [7:0] d);
    bsi_host_model_inst.x(w, a, d);
  endtask : x
  task automatic t_regs;
    x(0, 5'h15, 0); `CHK("mask rst", BSI_MASK_RESET, rd_data)
    x(1, 5'h15, 8'h55); x(0, 5'h15, 0); `CHK("mask", 8'h55, rd_data)
    x(0, 5'h03, 0); `CHK("unmapped", 8'h00, rd_data)
  endtask : t_regs
  task automatic t_hunt;
    x(0, 5'h14, 0); `CHK("hunt", 8'h10, rd_data)
    x(1, 5'h15, 8'h10); repeat (4) @(negedge clock); `CHK("irq", 1'b0, irq_n)
    x(1, 5'h15, 8'h00); repeat (4) @(negedge clock); `CHK("irq", 1'b1, irq_n)
  endtask : t_hunt
  task automatic t_lock;
    rx_in_lock = 1; repeat (6) @(negedge clock);
    x(0, 5'h14, 0); `CHK("after lock", 8'h11, rd_data)
    x(0, 5'h14, 0); `CHK("cleared", 8'h01, rd_data)
  endtask : t_lock
  task automatic t_events;
    x(1, 5'h15, 8'h02); {rx_bit_error, bit_count_wrap, error_count_wrap} = 3'b111;
    repeat (6) @(negedge clock); `CHK("irq", 1'b0, irq_n)
    x(0, 5'h14, 0); `CHK("events", 8'h0f, rd_data)
    {rx_bit_error, bit_count_wrap, error_count_wrap} = 3'b000;
    x(0, 5'h14, 0); `CHK("re-read", 8'h01, rd_data)
    repeat (3) @(negedge clock); `CHK("irq", 1'b1, irq_n)
  endtask : t_events
  // each bit needs a low and a high cycle so the synced edge is seen
  task automatic send_run(input logic b);
    rx_bit = b;
    repeat (34) begin
      rx_bit_valid = 1; @(negedge clock);
      rx_bit_valid = 0; @(negedge clock);
    end
    repeat (4) @(negedge clock);
  endtask : send_run
  task automatic t_runs;
    x(1, 5'h15, 8'h60); send_run(1);
    `CHK("irq", 1'b0, irq_n)
    x(0, 5'h14, 0); `CHK("ones", 8'h41, rd_data)
    send_run(0);
    x(0, 5'h14, 0); `CHK("zeros", 8'h61, rd_data)
    x(0, 5'h14, 0); `CHK("zeros kept", 8'h21, rd_data)
  endtask : t_runs
  task automatic end_sim;
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (2) @(negedge clock);
    rstn = 1;
    repeat (6) @(negedge clock);
    t_regs; t_hunt; t_lock; t_events; t_runs;
    end_sim;
  end
  initial begin
    #20000 failures++;
    end_sim;
  end
endmodule : bsi_status_irq_tb
